/* File: core/lsag_consts.svh */
// constants for the load/store address generator
`ifndef LSAG_CONSTS_SVH
`define LSAG_CONSTS_SVH
`define LSAG_ABS_SEG_POS 14
`define LSAG_ABS_LOW_W 14
`define LSAG_SOFF_W 10
`define LSAG_LOFF_W 16
`define LSAG_SEG_HI 31
`define LSAG_SEG_LO 28
`define LSAG_CIRC_BASE_ALIGN_MASK 32'h0000_0007
`define LSAG_WORD_ALIGN_MASK 32'h0000_0003
`define LSAG_HALF 16
`endif

/* File: core/lsag_pkg.sv */
// types for the load/store address generator
package lsag_pkg;
   // addressing modes
   typedef enum logic [2:0] {
      LSAG_ABS = 3'h0,
      LSAG_BSO = 3'h1,
      LSAG_BLO = 3'h2,
      LSAG_PRE = 3'h3,
      LSAG_POST = 3'h4,
      LSAG_CIRC = 3'h5,
      LSAG_BREV = 3'h6
   } lsag_mode_e;
   // operation kinds
   typedef enum logic [1:0] {
      LSAG_OP_PLAIN = 2'h0,
      LSAG_OP_RMW = 2'h1,
      LSAG_OP_SWAP = 2'h2,
      LSAG_OP_BIT = 2'h3
   } lsag_op_e;
   // access data size in bytes, log2
   typedef logic [1:0] lsag_size_t;
   // atomic sequencer states, one-hot
   typedef enum logic [3:0] {
      LSAG_ST_IDLE = 4'h1,
      LSAG_ST_READ = 4'h2,
      LSAG_ST_WRITE = 4'h4,
      LSAG_ST_DONE = 4'h8
   } lsag_state_e;
endpackage : lsag_pkg

/* File: core/lsag_rev16.sv */
// mirror of a 16-bit half, bit n swapped with bit 15-n
`timescale 1ns/10ps
module lsag_rev16 (
   // data
   input wire logic [15:0] din,
   output logic [15:0] dout
);
   // one mirror stage per bit
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_bit
         assign dout[gi] = din[15 - gi];
      end
   endgenerate
endmodule : lsag_rev16

/* File: core/lsag_circ_wrap.sv */
// circular index update with wrap into the buffer length
`timescale 1ns/10ps
`include "lsag_consts.svh"
module lsag_circ_wrap (
   // buffer state
   input wire logic [15:0] idx,
   input wire logic [15:0] len,
   input wire logic [9:0] offs,
   // next index
   output logic [15:0] nxt_idx
);
   logic signed [17:0] sum; // index plus signed offset
   always_comb begin
      sum = $signed({2'b00, idx}) + $signed({{8{offs[9]}}, offs});
      if (sum < 0) begin
         nxt_idx = 16'(sum + $signed({2'b00, len}));
      end else if (sum >= $signed({2'b00, len})) begin
         nxt_idx = 16'(sum - $signed({2'b00, len}));
      end else begin
         nxt_idx = sum[15:0];
      end
   end
endmodule : lsag_circ_wrap

/* File: core/lsag_top.sv */
// load/store effective address generator with atomic sequencer
`timescale 1ns/10ps
`include "lsag_consts.svh"
// Operation
// - absolute: top four constant bits to 31:28
// - base plus signed 10-bit offset, no update
// - base plus signed 16-bit offset
// - pre-increment: sum is address and write-back
// - post-increment: access base, write back sum
// - circular: base plus index from pair
// - circular index wraps by buffer length
// - circular offset is signed byte offset
// - circular overrun wraps to buffer start
// - trap on misaligned base or length
// - trap when index not below length
// - bit-reverse: base plus index from pair
// - bit-reverse index update by mirrored add
// - atomic ops read and write indivisibly
// - masked write of selected bits, no result
// - swap returns old memory word
// - atomics need read and write permission
// - load/update collision may take either value
// - trap on segment change by displacement
// - swap and masked write need word alignment
module lsag_top (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // decode request
   input wire logic req_valid,
   input wire lsag_pkg::lsag_mode_e req_mode,
   input wire lsag_pkg::lsag_op_e req_op,
   input wire lsag_pkg::lsag_size_t req_size,
   input wire logic req_store,
   input wire logic [17:0] req_abs,
   input wire logic [15:0] req_offs,
   input wire logic [31:0] req_base,
   input wire logic [31:0] req_pair_hi,
   input wire logic [31:0] req_src,
   input wire logic [31:0] req_mask,
   input wire logic [4:0] req_bit,
   input wire logic req_bit_val,
   input wire logic prot_en,
   input wire logic prot_rd_ok,
   input wire logic prot_wr_ok,
   output logic req_ready,
   // memory side
   output logic mem_req,
   output logic mem_we,
   output logic mem_lock,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   output logic [31:0] mem_wrap_addr,
   output logic mem_wrap,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   // register write-back
   output logic wb_valid,
   output logic wb_pair,
   output logic [31:0] wb_addr_reg,
   output logic [31:0] wb_pair_hi,
   output logic res_valid,
   output logic [31:0] res_data,
   // traps
   output logic alignment_trap,
   output logic mem_trap,
   output logic prot_trap
);
   logic [1:0] rst_sync_ff; // reset release chain
   logic rst_n; // synchronised reset
   lsag_pkg::lsag_state_e state_ff;
   lsag_pkg::lsag_state_e nxt_state;
   logic [31:0] ea; // effective address
   logic [31:0] upd; // updated address register
   logic [31:0] upd_hi; // updated odd register
   logic do_wb; // write-back wanted
   logic is_pair; // pair mode
   logic [31:0] s10; // sign-extended short offset
   logic [31:0] s16; // sign-extended long offset
   logic [15:0] c_len; // circular length / bit-rev modifier
   logic [15:0] c_idx; // pair index
   logic [15:0] circ_nxt; // circular next index
   logic [15:0] r_idx; // mirrored index
   logic [15:0] r_mod; // mirrored modifier
   logic [15:0] r_sum; // mirrored sum
   logic [15:0] brev_nxt; // bit-reverse next index
   logic [3:0] nbytes; // access size in bytes
   logic t_aln; // alignment trap cause
   logic t_seg; // segment trap cause
   logic t_prot; // protection trap cause
   logic atomic; // read-modify-write class op
   logic [31:0] lat_addr_ff; // held atomic address
   lsag_pkg::lsag_op_e lat_op_ff; // held atomic op
   logic [31:0] lat_src_ff;
   logic [31:0] lat_mask_ff;
   logic [31:0] old_ff; // memory word read

   // reset released through two flops
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   // offsets and pair fields
   assign s10 = {{22{req_offs[9]}}, req_offs[9:0]};
   assign s16 = {{16{req_offs[15]}}, req_offs};
   assign c_idx = req_pair_hi[15:0];
   assign c_len = req_pair_hi[31:16];
   assign nbytes = 4'(1) << req_size;
   assign atomic = (req_op != lsag_pkg::LSAG_OP_PLAIN);

   // circular index wrap
   lsag_circ_wrap u_circ (
      .idx(c_idx),
      .len(c_len),
      .offs(req_offs[9:0]),
      .nxt_idx(circ_nxt)
   );
   // bit-reverse index update
   lsag_rev16 u_rev_i (.din(c_idx), .dout(r_idx));
   lsag_rev16 u_rev_m (.din(c_len), .dout(r_mod));
   assign r_sum = r_idx + r_mod;
   lsag_rev16 u_rev_s (.din(r_sum), .dout(brev_nxt));

   // address and update per mode, all modulo 2^32
   always_comb begin
      ea = req_base;
      upd = req_base;
      upd_hi = req_pair_hi;
      do_wb = 1'b0;
      is_pair = 1'b0;
      case (req_mode)
         lsag_pkg::LSAG_ABS: begin
            ea = {req_abs[17:14], 14'h0000, req_abs[13:0]};
         end
         lsag_pkg::LSAG_BSO: begin
            ea = req_base + s10;
         end
         lsag_pkg::LSAG_BLO: begin
            ea = req_base + s16;
         end
         lsag_pkg::LSAG_PRE: begin
            ea = req_base + s10;
            upd = req_base + s10;
            do_wb = 1'b1;
         end
         lsag_pkg::LSAG_POST: begin
            ea = req_base;
            upd = req_base + s10;
            do_wb = 1'b1;
         end
         lsag_pkg::LSAG_CIRC: begin
            ea = req_base + {16'h0000, c_idx};
            upd_hi = {c_len, circ_nxt};
            do_wb = 1'b1;
            is_pair = 1'b1;
         end
         lsag_pkg::LSAG_BREV: begin
            ea = req_base + {16'h0000, c_idx};
            upd_hi = {c_len, brev_nxt};
            do_wb = 1'b1;
            is_pair = 1'b1;
         end
         default: begin
            ea = req_base;
         end
      endcase
   end

   // trap causes
   always_comb begin
      t_aln = 1'b0;
      t_seg = 1'b0;
      if (req_mode == lsag_pkg::LSAG_CIRC) begin
         t_aln = ((req_base & `LSAG_CIRC_BASE_ALIGN_MASK) != 32'h0)
            || ((c_len & 16'(nbytes - 4'h1)) != 16'h0)
            || (c_idx >= c_len);
      end
      if ((req_op == lsag_pkg::LSAG_OP_RMW) || (req_op == lsag_pkg::LSAG_OP_SWAP)) begin
         t_aln = t_aln || ((ea & `LSAG_WORD_ALIGN_MASK) != 32'h0);
      end
      if ((req_mode != lsag_pkg::LSAG_ABS) && (req_mode != lsag_pkg::LSAG_POST)) begin
         t_seg = ea[`LSAG_SEG_HI:`LSAG_SEG_LO] != req_base[`LSAG_SEG_HI:`LSAG_SEG_LO];
      end
      t_prot = atomic && prot_en && !(prot_rd_ok && prot_wr_ok);
   end

   // atomic sequencer next state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         lsag_pkg::LSAG_ST_IDLE: begin
            if (req_valid && atomic && !(t_aln || t_seg || t_prot)) begin
               nxt_state = lsag_pkg::LSAG_ST_READ;
            end
         end
         lsag_pkg::LSAG_ST_READ: begin
            if (mem_ack) begin
               nxt_state = lsag_pkg::LSAG_ST_WRITE;
            end
         end
         lsag_pkg::LSAG_ST_WRITE: begin
            if (mem_ack) begin
               nxt_state = lsag_pkg::LSAG_ST_DONE;
            end
         end
         lsag_pkg::LSAG_ST_DONE: begin
            nxt_state = lsag_pkg::LSAG_ST_IDLE;
         end
         default: begin
            nxt_state = lsag_pkg::LSAG_ST_IDLE;
         end
      endcase
   end

   // sequencer state
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= lsag_pkg::LSAG_ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // atomic operands held over the sequence
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         lat_addr_ff <= 32'h0000_0000;
         lat_op_ff <= lsag_pkg::LSAG_OP_PLAIN;
         lat_src_ff <= 32'h0000_0000;
         lat_mask_ff <= 32'h0000_0000;
         old_ff <= 32'h0000_0000;
      end else if (state_ff == lsag_pkg::LSAG_ST_IDLE && nxt_state == lsag_pkg::LSAG_ST_READ) begin
         lat_addr_ff <= ea;
         lat_op_ff <= req_op;
         lat_src_ff <= req_src;
         // single-bit store is a one-bit masked write
         lat_mask_ff <= (req_op == lsag_pkg::LSAG_OP_BIT) ? (32'h1 << req_bit) : req_mask;
         if (req_op == lsag_pkg::LSAG_OP_BIT) begin
            lat_src_ff <= {32{req_bit_val}};
         end
      end else if (state_ff == lsag_pkg::LSAG_ST_READ && mem_ack) begin
         old_ff <= mem_rdata;
      end
   end

   // memory port, locked across read and write
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_lock <= 1'b0;
         mem_addr <= 32'h0000_0000;
         mem_wdata <= 32'h0000_0000;
         mem_wrap <= 1'b0;
         mem_wrap_addr <= 32'h0000_0000;
      end else begin
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_wrap <= 1'b0;
         mem_lock <= (nxt_state == lsag_pkg::LSAG_ST_READ)
            || (nxt_state == lsag_pkg::LSAG_ST_WRITE);
         if (state_ff == lsag_pkg::LSAG_ST_IDLE && req_valid && !(t_aln || t_seg || t_prot)) begin
            mem_req <= 1'b1;
            mem_we <= req_store && !atomic;
            mem_addr <= ea;
            mem_wdata <= req_src;
            // bytes past the buffer end come from its start
            if (req_mode == lsag_pkg::LSAG_CIRC
               && ({16'h0000, c_idx} + {28'h0, nbytes}) > {16'h0000, c_len}) begin
               mem_wrap <= 1'b1;
               mem_wrap_addr <= req_base;
            end
         end else if (state_ff == lsag_pkg::LSAG_ST_READ && mem_ack) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_addr <= lat_addr_ff;
            if (lat_op_ff == lsag_pkg::LSAG_OP_SWAP) begin
               mem_wdata <= lat_src_ff;
            end else begin
               mem_wdata <= (mem_rdata & ~lat_mask_ff) | (lat_src_ff & lat_mask_ff);
            end
         end else if (state_ff != lsag_pkg::LSAG_ST_IDLE && !mem_ack) begin
            mem_req <= mem_req;
            mem_we <= mem_we;
         end
      end
   end

   // address register write-back and swap result
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_valid <= 1'b0;
         wb_pair <= 1'b0;
         wb_addr_reg <= 32'h0000_0000;
         wb_pair_hi <= 32'h0000_0000;
         res_valid <= 1'b0;
         res_data <= 32'h0000_0000;
      end else begin
         // a colliding load is not ordered against this write-back here
         wb_valid <= state_ff == lsag_pkg::LSAG_ST_IDLE && req_valid && do_wb
            && !(t_aln || t_seg || t_prot);
         wb_pair <= is_pair;
         wb_addr_reg <= upd;
         wb_pair_hi <= upd_hi;
         res_valid <= (state_ff == lsag_pkg::LSAG_ST_DONE) && (lat_op_ff == lsag_pkg::LSAG_OP_SWAP);
         res_data <= old_ff;
      end
   end

   // trap pulses
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         alignment_trap <= 1'b0;
         mem_trap <= 1'b0;
         prot_trap <= 1'b0;
         req_ready <= 1'b0;
      end else begin
         alignment_trap <= state_ff == lsag_pkg::LSAG_ST_IDLE && req_valid && t_aln;
         mem_trap <= state_ff == lsag_pkg::LSAG_ST_IDLE && req_valid && t_seg;
         prot_trap <= state_ff == lsag_pkg::LSAG_ST_IDLE && req_valid && t_prot;
         req_ready <= nxt_state == lsag_pkg::LSAG_ST_IDLE;
      end
   end
endmodule : lsag_top

/* File: tb/lsag_top_checker.sv */
// port assertions for the load/store address generator
`timescale 1ns/10ps
module lsag_top_checker (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // decode request
   input wire logic req_valid,
   input wire logic req_ready,
   input wire lsag_pkg::lsag_mode_e req_mode,
   input wire lsag_pkg::lsag_op_e req_op,
   input wire logic [17:0] req_abs,
   input wire logic [15:0] req_offs,
   input wire logic [31:0] req_base,
   // memory side and results
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic mem_lock,
   input wire logic [31:0] mem_addr,
   input wire logic mem_ack,
   input wire logic wb_valid,
   input wire logic [31:0] wb_addr_reg,
   input wire logic res_valid,
   input wire logic alignment_trap,
   input wire logic mem_trap,
   input wire logic prot_trap
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rstn);
   wire logic trap = alignment_trap | mem_trap | prot_trap; // any trap
   wire logic pl = req_valid & req_ready & (req_op == lsag_pkg::LSAG_OP_PLAIN); // plain take
   wire logic [31:0] s10 = {{22{req_offs[9]}}, req_offs[9:0]}; // short offset
   wire logic [31:0] absx = {req_abs[17:14], 14'h0, req_abs[13:0]}; // absolute address
   property p_take;
      req_valid && req_ready |=> mem_req || trap;
   endproperty
   a_take: assert property (p_take) else $error("request got no answer");
   property p_quiet;
      trap |-> !mem_req && !wb_valid;
   endproperty
   a_quiet: assert property (p_quiet) else $error("trap with access");
   property p_abs;
      pl && req_mode == lsag_pkg::LSAG_ABS |=> mem_req && mem_addr == $past(absx);
   endproperty
   a_abs: assert property (p_abs) else $error("absolute address wrong");
   property p_bso;
      pl && req_mode == lsag_pkg::LSAG_BSO |=> !wb_valid
         && (mem_trap || mem_addr == $past(req_base) + $past(s10));
   endproperty
   a_bso: assert property (p_bso) else $error("short offset wrong");
   property p_pre;
      pl && req_mode == lsag_pkg::LSAG_PRE |=> mem_trap || (wb_valid && wb_addr_reg == mem_addr);
   endproperty
   a_pre: assert property (p_pre) else $error("pre-increment wrong");
   property p_post;
      pl && req_mode == lsag_pkg::LSAG_POST |=> wb_valid && mem_addr == $past(req_base);
   endproperty
   a_post: assert property (p_post) else $error("post-increment wrong");
   property p_lockw;
      mem_req && mem_lock && !mem_we && mem_ack |=> mem_req && mem_we && mem_lock;
   endproperty
   a_lockw: assert property (p_lockw) else $error("atomic write not locked");
   property p_res;
      res_valid |-> $past(mem_we && mem_ack, 2);
   endproperty
   a_res: assert property (p_res) else $error("swap result mistimed");
   property p_busy;
      mem_lock |-> !req_ready;
   endproperty
   a_busy: assert property (p_busy) else $error("ready during atomic");
   // main scenarios reached
   c_atom: cover property (mem_we && mem_lock && mem_ack);
   c_aln: cover property (alignment_trap);
   c_wb: cover property (wb_valid);
endmodule : lsag_top_checker

/* File: tb/lsag_mem_model.sv */
// data memory partner answering after a set latency
`timescale 1ns/10ps
module lsag_mem_model (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // memory port
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   input wire logic [1:0] lat,
   output logic mem_ack,
   output logic [31:0] mem_rdata,
   // write log for the bench
   output logic [31:0] last_wdata,
   output logic [7:0] n_wr
);
   logic [1:0] cnt_ff; // cycles waited so far
   // ack after lat cycles; read data toggles when not answering
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mem_ack <= 1'b0;
         mem_rdata <= 32'h0;
         cnt_ff <= 2'h0;
         last_wdata <= 32'h0;
         n_wr <= 8'h0;
      end else begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
         cnt_ff <= 2'h0;
         if (mem_req && !mem_ack && cnt_ff < lat) begin
            cnt_ff <= cnt_ff + 2'h1;
         end else if (mem_req && !mem_ack) begin
            mem_ack <= 1'b1;
            mem_rdata <= {mem_addr[15:0] ^ 16'hA5C3, mem_addr[15:0]};
            if (mem_we) begin
               last_wdata <= mem_wdata;
               n_wr <= n_wr + 8'h1;
            end
         end
      end
   end
endmodule : lsag_mem_model

/* File: tb/test_lsag_top.sv */
// self-checking bench for the load/store address generator
`timescale 1ns/10ps
module test_lsag_top;
   logic core_clk, rstn, req_valid, req_store, req_bit_val, prot_en, prot_rd_ok, prot_wr_ok;
   lsag_pkg::lsag_mode_e req_mode;
   lsag_pkg::lsag_op_e req_op;
   lsag_pkg::lsag_size_t req_size;
   logic [17:0] req_abs;
   logic [15:0] req_offs, ln;
   logic [31:0] req_base, req_pair_hi, req_src, req_mask, mem_addr, mem_wdata, mem_rdata;
   logic [31:0] mem_wrap_addr, wb_addr_reg, wb_pair_hi, res_data, lastw, r, b, h;
   logic [4:0] req_bit;
   logic [2:0] m;
   logic [1:0] lat;
   logic [7:0] n_wr;
   logic req_ready, mem_req, mem_we, mem_lock, mem_wrap, mem_ack, wb_valid, wb_pair, res_valid;
   logic alignment_trap, mem_trap, prot_trap;
   logic [31:0] lfsr = 32'hF13B2187; // stimulus seed
   int n_errors = 0;
   int checks = 0;
   lsag_top u_dut (.core_clk, .rstn, .req_valid, .req_mode, .req_op, .req_size, .req_store,
      .req_abs, .req_offs, .req_base, .req_pair_hi, .req_src, .req_mask, .req_bit, .req_bit_val,
      .prot_en, .prot_rd_ok, .prot_wr_ok, .req_ready, .mem_req, .mem_we, .mem_lock, .mem_addr,
      .mem_wdata, .mem_wrap_addr, .mem_wrap, .mem_ack, .mem_rdata, .wb_valid, .wb_pair,
      .wb_addr_reg, .wb_pair_hi, .res_valid, .res_data, .alignment_trap, .mem_trap, .prot_trap);
   lsag_mem_model u_mem (.core_clk, .rstn, .mem_req, .mem_we, .mem_addr, .mem_wdata, .lat,
      .mem_ack, .mem_rdata, .last_wdata(lastw), .n_wr);
   // 25 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction : rnd
   // mirror of a 16-bit half
   function automatic logic [15:0] rv(input logic [15:0] x);
      for (int k = 0; k < 16; k++) rv[k] = x[15 - k];
   endfunction : rv
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic give_verdict();
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : give_verdict
   // bounded wait for the generator to be idle
   task automatic wait_ready();
      int i;
      for (i = 0; i < 64 && req_ready !== 1'b1; i++) @(negedge core_clk);
      if (i == 64) begin
         chk("ready", 32'h1, {31'h0, req_ready});
         give_verdict();
      end
   endtask : wait_ready
   // one request, taken at the next rising edge
   task automatic issue();
      @(negedge core_clk);
      wait_ready();
      req_valid = 1'b1;
      @(negedge core_clk);
      req_valid = 1'b0;
   endtask : issue
   // plain access: address, write-back and traps worked out here
   task automatic rp(input logic [2:0] md, input logic [31:0] bs, hi, input logic [15:0] o,
      input logic [1:0] sz);
      logic [31:0] s10, a, w;
      logic [17:0] t;
      logic [15:0] l, ix;
      logic tr, wv, wr, ci, br;
      s10 = {{22{o[9]}}, o[9:0]};
      l = hi[31:16];
      ix = hi[15:0];
      ci = md == 3'h5;
      br = md == 3'h6;
      a = md == 3'h4 ? bs : md == 3'h2 ? bs + {{16{o[15]}}, o} : bs + s10;
      w = bs + s10;
      if (md == 3'h0) a = {bs[17:14], 14'h0, bs[13:0]};
      if (ci || br) a = bs + {16'h0, ix};
      t = {2'h0, ix} + {{8{o[9]}}, o[9:0]};
      t = t[17] ? t + {2'h0, l} : t >= {2'h0, l} ? t - {2'h0, l} : t;
      if (ci) w = {l, t[15:0]};
      if (br) w = {l, rv(rv(ix) + rv(l))};
      tr = md != 3'h0 && md != 3'h4 && a[31:28] != bs[31:28];
      if (ci) tr = tr || bs[2:0] != 3'h0 || l % (16'h1 << sz) != 16'h0 || ix >= l;
      wr = ci && ({1'b0, ix} + (17'h1 << sz)) > {1'b0, l};
      wv = !tr && md >= 3'h3;
      req_mode = lsag_pkg::lsag_mode_e'(md);
      req_op = lsag_pkg::LSAG_OP_PLAIN;
      req_base = bs;
      req_pair_hi = hi;
      req_offs = o;
      req_abs = bs[17:0];
      req_size = sz;
      req_src = rnd();
      {prot_en, prot_rd_ok, req_store} = 3'(rnd());
      issue();
      chk("trap", tr, alignment_trap | mem_trap | prot_trap);
      chk("req", !tr, mem_req);
      chk("wbv", wv, wb_valid);
      if (!tr) chk("addr", a, mem_addr);
      if (wv) chk("wb", w, ci || br ? wb_pair_hi : wb_addr_reg);
      if (!tr && ci) chk("wrap", wr, mem_wrap);
      if (!tr && wr) chk("wrapa", bs, mem_wrap_addr);
      if (!tr) chk("we", req_store, mem_we);
      if (!tr) chk("pwdat", req_src, mem_wdata);
      if (wv) chk("pair", ci || br, wb_pair);
   endtask : rp
   // atomic access through the partner memory
   task automatic ra(input logic [1:0] op, input logic [31:0] bs, input logic pe, ok);
      logic [31:0] old, e;
      logic [7:0] k;
      logic tr;
      old = {bs[15:0] ^ 16'hA5C3, bs[15:0]};
      req_op = lsag_pkg::lsag_op_e'(op);
      req_mode = lsag_pkg::LSAG_BSO;
      req_base = bs;
      req_offs = 16'h0;
      req_src = rnd();
      req_mask = rnd();
      req_bit = req_src[9:5];
      req_bit_val = req_mask[0];
      prot_en = pe;
      prot_rd_ok = ok;
      prot_wr_ok = 1'b1;
      lat = 2'(rnd() % 3);
      tr = (op != 2'h3 && bs[1:0] != 2'h0) || (pe && !ok);
      e = op == 2'h1 ? (old & ~req_mask) | (req_src & req_mask) : op == 2'h2 ? req_src : old;
      if (op == 2'h3) e[req_bit] = req_bit_val;
      k = n_wr;
      issue();
      chk("atrap", tr, alignment_trap | prot_trap);
      wait_ready();
      chk("nwr", k + 8'(!tr), n_wr);
      if (!tr) chk("wdat", e, lastw);
      chk("resv", !tr && op == 2'h2, res_valid);
      if (!tr && op == 2'h2) chk("swap", old, res_data);
   endtask : ra
   // main sequence
   initial begin
      rstn = 1'b0;
      req_valid = 1'b0;
      lat = 2'h0;
      {req_store, req_bit_val, prot_en, prot_rd_ok, prot_wr_ok} = 5'h0;
      {req_abs, req_offs, req_base, req_pair_hi, req_src, req_mask, req_bit} = '0;
      req_mode = lsag_pkg::LSAG_ABS;
      req_op = lsag_pkg::LSAG_OP_PLAIN;
      req_size = 2'h0;
      repeat (16) @(negedge core_clk);
      rstn = 1'b1;
      rp(3'h0, 32'h0003_FFFF, 32'h0, 16'h0, 2'h0);
      rp(3'h1, 32'h1FFF_FFFE, 32'h0, 16'h4, 2'h0);
      rp(3'h1, 32'h2000_0010, 32'h0, 16'h3F0, 2'h0);
      rp(3'h2, 32'h3000_0000, 32'h0, 16'h8000, 2'h0);
      rp(3'h2, 32'h3000_9000, 32'h0, 16'h8000, 2'h0);
      rp(3'h3, 32'h4000_0100, 32'h0, 16'h3FC, 2'h0);
      rp(3'h4, 32'h4FFF_FFFC, 32'h0, 16'h4, 2'h0);
      rp(3'h5, 32'h5000_0000, 32'h0032_0030, 16'h2, 2'h1);
      rp(3'h5, 32'h5000_0000, 32'h0032_0030, 16'h4, 2'h1);
      rp(3'h5, 32'h5000_0000, 32'h0032_0004, 16'h3F8, 2'h1);
      rp(3'h5, 32'h5000_0000, 32'h0034_0032, 16'h4, 2'h2);
      rp(3'h5, 32'h5000_0004, 32'h0034_0000, 16'h4, 2'h2);
      rp(3'h5, 32'h5000_0000, 32'h0032_0000, 16'h4, 2'h2);
      rp(3'h5, 32'h5000_0000, 32'h0034_0034, 16'h4, 2'h1);
      rp(3'h6, 32'h6000_0000, 32'h0400_0000, 16'h0, 2'h1);
      rp(3'h6, 32'h6000_0000, 32'h0400_0400, 16'h0, 2'h1);
      for (int p = 0; p < 6; p++) ra(2'(p % 3 + 1), 32'h7000_0040, 1'b0, 1'b1);
      ra(2'h2, 32'h7000_0042, 1'b0, 1'b1);
      ra(2'h1, 32'h7000_0048, 1'b1, 1'b0);
      ra(2'h3, 32'h7000_0051, 1'b1, 1'b1);
      for (int n = 0; n < 150; n++) begin
         r = rnd();
         ln = 16'h208 + {5'h0, r[7:0], 3'h0};
         m = 3'(r[31:24] % 7);
         b = r[10] ? rnd() : rnd() & 32'hFFFF_FFF8;
         h = m == 3'h5 ? {ln, 16'(rnd() % ln)} : rnd();
         rp(m, b, h, 16'(rnd()), 2'(r[13:12]));
      end
      give_verdict();
   end
endmodule : test_lsag_top
bind lsag_top lsag_top_checker u_chk (.core_clk, .rstn, .req_valid, .req_ready, .req_mode,
   .req_op, .req_abs, .req_offs, .req_base, .mem_req, .mem_we, .mem_lock, .mem_addr, .mem_ack,
   .wb_valid, .wb_addr_reg, .res_valid, .alignment_trap, .mem_trap, .prot_trap);
